// *** hw/tpnvm_pkg.sv ***
package tpnvm_pkg;
   localparam int PTR_W      = 22;
   localparam int PTR_LO_W   = 21;
   localparam int WR_BLK_LSB = 3;
   localparam int ER_BLK_LSB = 6;

   // special function register selects
   localparam logic [2:0] SFR_PTR_LOW   = 3'h0;
   localparam logic [2:0] SFR_PTR_HIGH  = 3'h1;
   localparam logic [2:0] SFR_PTR_UPPER = 3'h2;
   localparam logic [2:0] SFR_LATCH     = 3'h3;
   localparam logic [2:0] SFR_CTL       = 3'h4;

   // nvm_control bit positions
   localparam int CTL_RD     = 0;
   localparam int CTL_WR     = 1;
   localparam int CTL_UNLOCK = 2;
   localparam int CTL_ERR    = 3;
   localparam int CTL_FREE   = 4;
   localparam int CTL_CFG    = 6;
   localparam int CTL_PGD    = 7;

   localparam logic [7:0] CTL_RESET     = 8'h00;
   localparam logic [7:0] PTR_RESET     = 8'h00;
   localparam logic [7:0] LATCH_RESET   = 8'h00;
   localparam logic [7:0] UPPER_RD_MASK = 8'h3F;

   typedef enum logic [1:0] {
      TM_KEEP    = 2'h0,
      TM_POSTINC = 2'h1,
      TM_POSTDEC = 2'h2,
      TM_PREINC  = 2'h3
   } tpnvm_tmode_type;

   typedef enum logic [1:0] {
      SPACE_EE    = 2'h0,
      SPACE_FLASH = 2'h1,
      SPACE_CFG   = 2'h2
   } tpnvm_space_type;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_RDREQ = 2'b01,
      ST_RDCAP = 2'b11,
      ST_PROG  = 2'b10
   } tpnvm_state_type;
endpackage

// *** hw/tpnvm_ptr_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface tpnvm_ptr_if;
   import tpnvm_pkg::*;
   logic [PTR_W-1:0] ptr;
   tpnvm_tmode_type  mode;
   logic [PTR_W-1:0] access_addr;
   logic [PTR_W-1:0] next_ptr;
   modport calc (input ptr, input mode, output access_addr, output next_ptr);
   modport user (output ptr, output mode, input access_addr, input next_ptr);
endinterface
`default_nettype wire

// *** hw/tpnvm_ptr_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpnvm_ptr_unit (
   tpnvm_ptr_if.calc p
);
   import tpnvm_pkg::*;

   function automatic logic [PTR_LO_W-1:0] step(input logic [PTR_LO_W-1:0] v,
                                                input logic             up);
      step = up ? PTR_LO_W'(v + 1'b1) : PTR_LO_W'(v - 1'b1);
   endfunction

   logic [PTR_W-1:0] incd;
   logic [PTR_W-1:0] decd;

   // top bit never carries or borrows
   assign incd = {p.ptr[PTR_W-1], step(p.ptr[PTR_LO_W-1:0], 1'b1)};
   assign decd = {p.ptr[PTR_W-1], step(p.ptr[PTR_LO_W-1:0], 1'b0)};

   always_comb begin
      p.access_addr = (p.mode == TM_PREINC) ? incd : p.ptr;
      case (p.mode)
         TM_KEEP:    p.next_ptr = p.ptr;
         TM_POSTINC: p.next_ptr = incd;
         TM_POSTDEC: p.next_ptr = decd;
         TM_PREINC:  p.next_ptr = incd;
         default:    p.next_ptr = p.ptr;
      endcase
   end
endmodule
`default_nettype wire

// *** hw/tpnvm_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpnvm_top (
   input  wire logic                       clk,
   input  wire logic                       reset_n,
   input  wire logic                       ce,
   input  wire logic                       warm_reset,
   input  wire logic [2:0]                 sfr_sel,
   input  wire logic                       sfr_we,
   input  wire logic [7:0]                 sfr_wdata,
   output logic      [7:0]                 sfr_rdata,
   input  wire logic                       tbl_req,
   input  wire logic                       tbl_write,
   input  wire tpnvm_pkg::tpnvm_tmode_type tbl_mode,
   output logic                            tbl_done,
   output logic                            prog_rd_en,
   output logic      [tpnvm_pkg::PTR_W-1:0] prog_addr,
   input  wire logic [7:0]                 prog_rdata,
   output logic                            hold_we,
   output logic      [tpnvm_pkg::PTR_W-1:0] hold_addr,
   output logic      [7:0]                 hold_data,
   output logic                            mem_start,
   output logic                            mem_erase,
   output tpnvm_pkg::tpnvm_space_type      mem_space,
   output logic      [tpnvm_pkg::PTR_W-1:0] mem_addr,
   output logic                            mem_abort,
   input  wire logic                       mem_done,
   output logic                            ee_rd_strobe,
   output logic                            nvm_busy
);
   import tpnvm_pkg::*;

   typedef struct packed {
      tpnvm_state_type  st;
      logic [PTR_W-1:0] ptr;
      logic [7:0]       latch;
      logic [7:0]       ctl;
      logic [7:0]       rdata;
      logic             tbl_done;
      logic             prog_rd_en;
      logic [PTR_W-1:0] prog_addr;
      logic             hold_we;
      logic [PTR_W-1:0] hold_addr;
      logic [7:0]       hold_data;
      logic             mem_start;
      logic             mem_erase;
      tpnvm_space_type  mem_space;
      logic [PTR_W-1:0] mem_addr;
      logic             mem_abort;
      logic             ee_rd;
      logic             busy;
   } tpnvm_regs_type;

   tpnvm_regs_type r_reg;
   tpnvm_regs_type r_next;

   tpnvm_ptr_if pu ();

   tpnvm_ptr_unit u_ptr (
      .p (pu.calc)
   );

   assign pu.ptr  = r_reg.ptr;
   assign pu.mode = tbl_mode;

   function automatic tpnvm_space_type space_of(input logic [7:0] c);
      if (c[CTL_CFG]) begin
         space_of = SPACE_CFG;
      end else if (c[CTL_PGD]) begin
         space_of = SPACE_FLASH;
      end else begin
         space_of = SPACE_EE;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic [7:0] w;
      w = sfr_wdata;
      r_next = r_reg;
      r_next.tbl_done   = 1'b0;
      r_next.prog_rd_en = 1'b0;
      r_next.hold_we    = 1'b0;
      r_next.mem_start  = 1'b0;
      r_next.mem_abort  = 1'b0;
      r_next.ee_rd      = 1'b0;
      r_next.ctl[CTL_RD] = 1'b0;
      case (r_sel_fix(sfr_sel))
         SFR_PTR_LOW:   r_next.rdata = r_reg.ptr[7:0];
         SFR_PTR_HIGH:  r_next.rdata = r_reg.ptr[15:8];
         SFR_PTR_UPPER: r_next.rdata = 8'(r_reg.ptr[PTR_W-1:16]) & UPPER_RD_MASK;
         SFR_LATCH:     r_next.rdata = r_reg.latch;
         SFR_CTL:       r_next.rdata = r_reg.ctl;
         default:       r_next.rdata = 8'h00;
      endcase

      if (sfr_we) begin
         case (sfr_sel)
            SFR_PTR_LOW:   r_next.ptr[7:0]        = w;
            SFR_PTR_HIGH:  r_next.ptr[15:8]       = w;
            SFR_PTR_UPPER: r_next.ptr[PTR_W-1:16] = w[PTR_W-17:0];
            SFR_LATCH:     r_next.latch           = w;
            SFR_CTL: begin
               r_next.ctl[CTL_PGD]  = w[CTL_PGD];
               r_next.ctl[CTL_CFG]  = w[CTL_CFG];
               r_next.ctl[CTL_FREE] = w[CTL_FREE];
               r_next.ctl[CTL_UNLOCK] = w[CTL_UNLOCK];
               r_next.ctl[CTL_ERR]  = w[CTL_ERR];
               if (w[CTL_RD] && !w[CTL_PGD] && !w[CTL_CFG] && r_reg.st == ST_IDLE) begin
                  r_next.ctl[CTL_RD] = 1'b1;
                  r_next.ee_rd       = 1'b1;
               end
               if (w[CTL_WR] && !r_reg.ctl[CTL_WR] && r_reg.st == ST_IDLE) begin
                  if (r_reg.ctl[CTL_UNLOCK]) begin
                     r_next.ctl[CTL_WR] = 1'b1;
                     r_next.st          = ST_PROG;
                     r_next.mem_start   = 1'b1;
                     r_next.mem_erase   = w[CTL_FREE];
                     r_next.mem_space   = space_of(w);
                     if (w[CTL_FREE]) begin
                        r_next.mem_addr = {r_reg.ptr[PTR_W-1:ER_BLK_LSB],
                                           ER_BLK_LSB'(0)};
                     end else begin
                        r_next.mem_addr = {r_reg.ptr[PTR_W-1:WR_BLK_LSB],
                                           WR_BLK_LSB'(0)};
                     end
                  end else begin
                     r_next.ctl[CTL_ERR] = 1'b1;
                  end
               end
            end
            default: begin
            end
         endcase
      end

      case (r_reg.st)
         ST_IDLE: begin
            if (tbl_req) begin
               r_next.ptr = pu.next_ptr;
               if (tbl_write) begin
                  r_next.hold_we   = 1'b1;
                  r_next.hold_addr = pu.access_addr;
                  r_next.hold_data = r_reg.latch;
                  r_next.tbl_done  = 1'b1;
               end else begin
                  r_next.prog_rd_en = 1'b1;
                  r_next.prog_addr  = pu.access_addr;
                  r_next.st         = ST_RDREQ;
               end
            end
         end
         ST_RDREQ: r_next.st = ST_RDCAP;
         ST_RDCAP: begin
            r_next.latch    = prog_rdata;
            r_next.tbl_done = 1'b1;
            r_next.st       = ST_IDLE;
         end
         ST_PROG: begin
            if (mem_done) begin
               r_next.ctl[CTL_WR] = 1'b0;
               if (r_reg.mem_erase) begin
                  r_next.ctl[CTL_FREE] = 1'b0;
               end
               r_next.st = ST_IDLE;
            end
         end
         default: r_next.st = ST_IDLE;
      endcase

      // warm reset clears pointer/latch, keeps space selects for tracing
      if (warm_reset) begin
         r_next.ptr        = {PTR_W{1'b0}};
         r_next.latch      = LATCH_RESET;
         r_next.ctl[CTL_FREE] = 1'b0;
         r_next.ctl[CTL_UNLOCK] = 1'b0;
         r_next.ctl[CTL_WR]   = 1'b0;
         r_next.ctl[CTL_RD]   = 1'b0;
         r_next.st         = ST_IDLE;
         r_next.tbl_done   = 1'b0;
         r_next.prog_rd_en = 1'b0;
         r_next.hold_we    = 1'b0;
         r_next.mem_start  = 1'b0;
         r_next.ee_rd      = 1'b0;
         // selects and error flag survive a same-cycle control write
         r_next.ctl[CTL_PGD] = r_reg.ctl[CTL_PGD];
         r_next.ctl[CTL_CFG] = r_reg.ctl[CTL_CFG];
         r_next.ctl[CTL_ERR] = r_reg.ctl[CTL_ERR];
         if (r_reg.st == ST_PROG) begin
            r_next.mem_abort    = 1'b1;
            r_next.ctl[CTL_ERR] = 1'b1;
         end
      end
      r_next.ctl[5] = 1'b0;
      r_next.busy   = (r_next.st != ST_IDLE);
   end

   function automatic logic [2:0] r_sel_fix(input logic [2:0] s);
      r_sel_fix = s;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r_reg <= '{st: ST_IDLE, ctl: CTL_RESET, latch: LATCH_RESET,
                    mem_space: SPACE_EE, default: '0};
      end else if (ce) begin
         r_reg <= r_next;
      end
   end

   assign sfr_rdata    = r_reg.rdata;
   assign tbl_done     = r_reg.tbl_done;
   assign prog_rd_en   = r_reg.prog_rd_en;
   assign prog_addr    = r_reg.prog_addr;
   assign hold_we      = r_reg.hold_we;
   assign hold_addr    = r_reg.hold_addr;
   assign hold_data    = r_reg.hold_data;
   assign mem_start    = r_reg.mem_start;
   assign mem_erase    = r_reg.mem_erase;
   assign mem_space    = r_reg.mem_space;
   assign mem_addr     = r_reg.mem_addr;
   assign mem_abort    = r_reg.mem_abort;
   assign ee_rd_strobe = r_reg.ee_rd;
   assign nvm_busy     = r_reg.busy;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n || !ce);

   logic idle_tbl;
   assign idle_tbl = tbl_req && r_reg.st == ST_IDLE && !warm_reset;

   property p_latch_load;
      (r_reg.st == ST_RDCAP && !warm_reset) |=> (r_reg.latch == $past(prog_rdata)) && tbl_done;
   endproperty
   a_latch_load: assert property (p_latch_load) else $error("latch not loaded");

   property p_read_seq;
      (idle_tbl && !tbl_write && tbl_mode == TM_KEEP)
         |=> prog_rd_en && prog_addr == $past(r_reg.ptr) ##2 tbl_done;
   endproperty
   a_read_seq: assert property (p_read_seq) else $error("table read address wrong");

   property p_top_bit;
      idle_tbl |=> r_reg.ptr[PTR_W-1] == $past(r_reg.ptr[PTR_W-1]);
   endproperty
   a_top_bit: assert property (p_top_bit) else $error("pointer top bit changed");

   property p_postinc;
      (idle_tbl && tbl_mode == TM_POSTINC)
         |=> r_reg.ptr[PTR_LO_W-1:0] == PTR_LO_W'($past(r_reg.ptr[PTR_LO_W-1:0]) + 1'b1);
   endproperty
   a_postinc: assert property (p_postinc) else $error("post-increment wrong");

   property p_preinc_addr;
      (idle_tbl && tbl_write && tbl_mode == TM_PREINC)
         |=> hold_we && hold_addr == r_reg.ptr && hold_data == $past(r_reg.latch);
   endproperty
   a_preinc_addr: assert property (p_preinc_addr) else $error("pre-increment wrong");

   property p_wr_block;
      (mem_start && !mem_erase) |-> mem_addr[WR_BLK_LSB-1:0] == '0;
   endproperty
   a_wr_block: assert property (p_wr_block) else $error("write block unaligned");

   property p_er_block;
      (mem_start && mem_erase) |-> mem_addr[ER_BLK_LSB-1:0] == '0 && r_reg.ctl[CTL_FREE];
   endproperty
   a_er_block: assert property (p_er_block) else $error("erase block unaligned");

   property p_unlock;
      mem_start |-> $past(r_reg.ctl[CTL_UNLOCK]) && r_reg.ctl[CTL_WR] && nvm_busy;
   endproperty
   a_unlock: assert property (p_unlock) else $error("write without unlock");

   property p_done_clear;
      (r_reg.st == ST_PROG && mem_done && !warm_reset) |=> !r_reg.ctl[CTL_WR] && !nvm_busy;
   endproperty
   a_done_clear: assert property (p_done_clear) else $error("write bit not cleared");

   property p_locked_err;
      (sfr_we && sfr_sel == SFR_CTL && sfr_wdata[CTL_WR] && !r_reg.ctl[CTL_UNLOCK]
       && r_reg.st == ST_IDLE && !warm_reset) |=> r_reg.ctl[CTL_ERR] && !mem_start;
   endproperty
   a_locked_err: assert property (p_locked_err) else $error("locked write not refused");

   property p_abort_err;
      (r_reg.st == ST_PROG && warm_reset)
         |=> mem_abort && r_reg.ctl[CTL_ERR] && r_reg.ctl[CTL_PGD] == $past(r_reg.ctl[CTL_PGD]);
   endproperty
   a_abort_err: assert property (p_abort_err) else $error("abort not flagged");

   property p_ee_read;
      ee_rd_strobe |-> r_reg.ctl[CTL_RD] && !r_reg.ctl[CTL_PGD] && !r_reg.ctl[CTL_CFG];
   endproperty
   a_ee_read: assert property (p_ee_read) else $error("read in wrong space");

   property p_rd_clear;
      (ee_rd_strobe && !(sfr_we && sfr_sel == SFR_CTL)) |=> !r_reg.ctl[CTL_RD] && !ee_rd_strobe;
   endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("read bit stuck");

   property p_warm_clear;
      warm_reset |=> r_reg.ptr == '0 && r_reg.latch == LATCH_RESET && !r_reg.ctl[CTL_UNLOCK];
   endproperty
   a_warm_clear: assert property (p_warm_clear) else $error("warm reset left state");

   property p_space_sel;
      mem_start |-> ((mem_space == SPACE_CFG) == r_reg.ctl[CTL_CFG])
         && ((mem_space == SPACE_EE) == !(r_reg.ctl[CTL_PGD] || r_reg.ctl[CTL_CFG]));
   endproperty
   a_space_sel: assert property (p_space_sel) else $error("wrong memory space");

   c_tbl_read:  cover property (r_reg.st == ST_RDCAP ##1 tbl_done);
   c_erase:     cover property (mem_start && mem_erase);
   c_write_ok:  cover property (r_reg.st == ST_PROG && mem_done);
   c_abort:     cover property (mem_abort);
endmodule
`default_nettype wire

// *** verif/tpnvm_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpnvm_mem_model (
   input  wire logic                        clk,
   input  wire logic                        reset_n,
   input  wire logic                        slow,
   input  wire logic                        prog_rd_en,
   input  wire logic [tpnvm_pkg::PTR_W-1:0] prog_addr,
   output logic      [7:0]                  prog_rdata,
   input  wire logic                        mem_start,
   input  wire logic                        mem_abort,
   output logic                             mem_done
);
   import tpnvm_pkg::*;
   logic [5:0] cnt_reg;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prog_rdata <= 8'h00;
         cnt_reg    <= 6'h00;
         mem_done   <= 1'b0;
      end else begin
         // byte valid one cycle only, then scrambled
         prog_rdata <= prog_rd_en ? (prog_addr[7:0] ^ {2'h0, prog_addr[21:16]}) : ~prog_rdata;
         mem_done   <= (cnt_reg == 6'h01) && !mem_abort;
         if (mem_abort) begin
            cnt_reg <= 6'h00;
         end else if (mem_start) begin
            cnt_reg <= slow ? 6'h14 : 6'h02;
         end else if (cnt_reg != 6'h00) begin
            cnt_reg <= cnt_reg - 6'h01;
         end
      end
   end
endmodule
`default_nettype wire

// *** verif/tb_table_pointer_nvm_access.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_table_pointer_nvm_access;
   import tpnvm_pkg::*;
   typedef struct packed {
      logic [1:0]  m;
      logic [21:0] p;
      logic [21:0] a;
      logic [21:0] n;
   } tpnvm_row_type;
   logic             clk, reset_n, ce, warm_reset, sfr_we, tbl_req, tbl_write, slow;
   logic [2:0]       sfr_sel;
   logic [7:0]       sfr_wdata, sfr_rdata, prog_rdata, hold_data, v;
   tpnvm_tmode_type  tbl_mode;
   logic             tbl_done, prog_rd_en, hold_we, mem_start, mem_erase, mem_abort;
   logic             mem_done, ee_rd_strobe, nvm_busy;
   logic [PTR_W-1:0] prog_addr, hold_addr, mem_addr, p;
   tpnvm_space_type  mem_space;
   int               err_total;
   int               n_tests;
   time              we_drop;
   tpnvm_row_type    rows [6] = '{
      '{2'h0, 22'h2ABCDE, 22'h2ABCDE, 22'h2ABCDE},
      '{2'h1, 22'h3FFFFF, 22'h3FFFFF, 22'h200000},
      '{2'h2, 22'h200000, 22'h200000, 22'h3FFFFF},
      '{2'h3, 22'h1FFFFF, 22'h000000, 22'h000000},
      '{2'h1, 22'h012345, 22'h012345, 22'h012346},
      '{2'h3, 22'h2000FF, 22'h200100, 22'h200100}};

   tpnvm_top u_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .warm_reset(warm_reset),
      .sfr_sel(sfr_sel), .sfr_we(sfr_we), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .tbl_req(tbl_req), .tbl_write(tbl_write), .tbl_mode(tbl_mode), .tbl_done(tbl_done),
      .prog_rd_en(prog_rd_en), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
      .hold_we(hold_we), .hold_addr(hold_addr), .hold_data(hold_data),
      .mem_start(mem_start), .mem_erase(mem_erase), .mem_space(mem_space),
      .mem_addr(mem_addr), .mem_abort(mem_abort), .mem_done(mem_done),
      .ee_rd_strobe(ee_rd_strobe), .nvm_busy(nvm_busy));
   tpnvm_mem_model u_mem (.clk(clk), .reset_n(reset_n), .slow(slow),
      .prog_rd_en(prog_rd_en), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
      .mem_start(mem_start), .mem_abort(mem_abort), .mem_done(mem_done));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask
   task automatic wr(input logic [2:0] s, input logic [7:0] d);
      // let an edge pass so the strobe is never dropped and raised at once
      if (we_drop == $time) @(negedge clk);
      sfr_sel = s;
      sfr_wdata = d;
      sfr_we = 1'b1;
      @(negedge clk);
      sfr_we = 1'b0;
      we_drop = $time;
   endtask
   task automatic rd(input logic [2:0] s, output logic [7:0] d);
      sfr_sel = s;
      repeat (2) @(negedge clk);
      d = sfr_rdata;
   endtask
   task automatic setptr(input logic [21:0] a);
      wr(SFR_PTR_UPPER, {2'h0, a[21:16]});
      wr(SFR_PTR_HIGH, a[15:8]);
      wr(SFR_PTR_LOW, a[7:0]);
   endtask
   task automatic rdptr(output logic [21:0] a);
      logic [7:0] u, h, l;
      rd(SFR_PTR_UPPER, u);
      rd(SFR_PTR_HIGH, h);
      rd(SFR_PTR_LOW, l);
      a = {u[5:0], h, l};
   endtask
   task automatic tbl(input logic w, input tpnvm_tmode_type m);
      tbl_write = w;
      tbl_mode = m;
      tbl_req = 1'b1;
      @(negedge clk);
      tbl_req = 1'b0;
   endtask
   task automatic waitbusy;
      for (int k = 0; k < 40; k++) begin
         if (nvm_busy !== 1'b1) break;
         @(negedge clk);
      end
      chk(nvm_busy, 1'b0);
   endtask
   task automatic start(input logic [7:0] c);
      wr(SFR_CTL, c & 8'hFD);
      wr(SFR_CTL, c);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      summarize();
   end
   initial begin
      {reset_n, warm_reset, sfr_we, tbl_req, tbl_write, slow} = '0;
      ce = 1'b1;
      sfr_sel = 3'h0;
      sfr_wdata = 8'h00;
      tbl_mode = TM_KEEP;
      err_total = 0;
      n_tests = 0;
      repeat (10) @(negedge clk);
      reset_n = 1'b1;
      foreach (rows[i]) begin
         setptr(rows[i].p);
         tbl(1'b0, tpnvm_tmode_type'(rows[i].m));
         chk(prog_rd_en, 1'b1);
         chk(prog_addr, rows[i].a);
         repeat (2) @(negedge clk);
         chk(tbl_done, 1'b1);
         rd(SFR_LATCH, v);
         chk(v, rows[i].a[7:0] ^ {2'h0, rows[i].a[21:16]});
         rdptr(p);
         chk(p, rows[i].n);
      end
      setptr(22'h2000F5);
      wr(SFR_LATCH, 8'h5A);
      tbl(1'b1, TM_POSTDEC);
      chk({hold_we, tbl_done, hold_data}, 10'h35A);
      chk(hold_addr, 22'h2000F5);
      rdptr(p);
      chk(p, 22'h2000F4);
      tbl(1'b1, TM_PREINC);
      chk(hold_addr, 22'h2000F5);
      rdptr(p);
      chk(p, 22'h2000F5);
      setptr(22'h01234D);
      slow = 1'b1;
      start(8'h86);
      chk({mem_start, mem_erase, mem_space}, 4'h9);
      chk(mem_addr, 22'h012348);
      tbl(1'b0, TM_POSTINC);
      chk(prog_rd_en, 1'b0);
      wr(SFR_CTL, 8'h84);
      rd(SFR_CTL, v);
      chk(v, 8'h86);
      waitbusy();
      rd(SFR_CTL, v);
      chk(v, 8'h84);
      slow = 1'b0;
      start(8'h96);
      chk({mem_start, mem_erase}, 2'h3);
      chk(mem_addr, 22'h012340);
      waitbusy();
      rd(SFR_CTL, v);
      chk(v, 8'h84);
      setptr(22'h300007);
      start(8'hC6);
      chk({mem_start, mem_space}, {1'b1, SPACE_CFG});
      chk(mem_addr, 22'h300000);
      waitbusy();
      start(8'h06);
      chk({mem_start, mem_space}, {1'b1, SPACE_EE});
      waitbusy();
      wr(SFR_CTL, 8'h01);
      chk(ee_rd_strobe, 1'b1);
      rd(SFR_CTL, v);
      chk(v, 8'h00);
      for (int k = 0; k < 2; k++) begin
         wr(SFR_CTL, k ? 8'h41 : 8'h81);
         chk(ee_rd_strobe, 1'b0);
         rd(SFR_CTL, v);
         chk(v, k ? 8'h40 : 8'h80);
      end
      wr(SFR_CTL, 8'hC0);
      wr(SFR_CTL, 8'hC2);
      chk({mem_start, nvm_busy}, 2'h0);
      rd(SFR_CTL, v);
      chk(v, 8'hC8);
      setptr(22'h000010);
      wr(SFR_LATCH, 8'h33);
      slow = 1'b1;
      start(8'h86);
      warm_reset = 1'b1;
      @(negedge clk);
      warm_reset = 1'b0;
      chk(mem_abort, 1'b1);
      rd(SFR_CTL, v);
      chk(v, 8'h88);
      rdptr(p);
      chk(p, 22'h0);
      wr(SFR_PTR_UPPER, 8'hFF);
      rd(SFR_PTR_UPPER, v);
      chk(v, UPPER_RD_MASK);
      rd(3'h7, v);
      chk(v, 8'h00);
      ce = 1'b0;
      wr(SFR_LATCH, 8'hA5);
      ce = 1'b1;
      rd(SFR_LATCH, v);
      chk(v, LATCH_RESET);
      reset_n = 1'b0;
      @(negedge clk);
      reset_n = 1'b1;
      chk({mem_start, nvm_busy, mem_abort}, 3'h0);
      for (int k = 0; k < 5; k++) begin
         rd(3'(k), v);
         chk(v, 8'h00);
      end
      summarize();
   end
endmodule
`default_nettype wire
